/* File: logic/comreset_detect.sv */
// Purpose: spots a host reset burst train on the receive squelch level
// Assumes: i_rx_burst is high while a burst is on the line
// Notes: output falls once the line stays idle past the longest gap
`timescale 1ns/1ps
`default_nettype none
`include "oob_init_defines.svh"

module comreset_detect (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_rx_burst,
	output logic o_comreset
);
	// gap counter saturates one past the window so long idles stay long
	localparam logic [4:0] GAP_MIN = 5'(`RST_GAP_MIN_CYC);
	localparam logic [4:0] GAP_MAX = 5'(`RST_GAP_MAX_CYC);

	logic burst_q; // previous squelch level for edge finding
	logic [4:0] gap; // idle cycles since the last burst ended
	logic [2:0] bursts; // bursts in the current run: the opening burst plus those with in-window spacing

	wire burst_rise = i_rx_burst & ~burst_q;
	wire gap_ok = (gap >= GAP_MIN) && (gap <= GAP_MAX);
	wire gap_long = gap > GAP_MAX;

	// measure idle gaps between bursts
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			burst_q <= 1'b0;
			gap <= 5'h0;
		end else begin
			burst_q <= i_rx_burst;
			if (i_rx_burst)
				gap <= 5'h0;
			else if (!gap_long)
				gap <= gap + 5'h1;
		end
	end

	// count consecutive good bursts, a bad spacing restarts the run
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bursts <= 3'h0;
			o_comreset <= 1'b0;
		end else begin
			if (burst_rise) begin
				if (gap_ok && bursts != `RST_BURSTS)
					bursts <= bursts + 3'h1;
				else if (!gap_ok)
					bursts <= 3'h1; // this burst opens a new run
			end else if (gap_long) begin
				bursts <= 3'h0;
			end
			// out-of-window spacing or release negates the output
			if (gap_long || (burst_rise && !gap_ok))
				o_comreset <= 1'b0;
			else if (bursts == `RST_BURSTS)
				o_comreset <= 1'b1;
		end
	end
endmodule // comreset_detect
`default_nettype wire

/* File: logic/oob_init_defines.svh */
// Purpose: constants for the device out-of-band link bring-up block
// Assumes: 40 MHz core clock, every time figure converted to core cycles
// Notes: least times round up, longest times round down
`ifndef OOB_INIT_DEFINES_SVH
`define OOB_INIT_DEFINES_SVH

// core clock period in picoseconds
`define CLK_PERIOD_PS 25000
`define PS_CEIL_CYC(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PS_FLOOR_CYC(ps) ((ps) / `CLK_PERIOD_PS)

// align negotiation window, one speed step (54.6 us)
`define ALIGN_WAIT_PS 54600000
`define ALIGN_WAIT_CYC `PS_CEIL_CYC(`ALIGN_WAIT_PS)
// extended align window including receiver lock time (109.2 us)
`define ALIGN_WAIT_LONG_PS 109200000
`define ALIGN_WAIT_LONG_CYC `PS_CEIL_CYC(`ALIGN_WAIT_LONG_PS)
// idle after comwake during which received align is not trusted (533 ns)
`define ALIGN_BLANK_PS 533000
`define ALIGN_BLANK_CYC `PS_CEIL_CYC(`ALIGN_BLANK_PS)
// longest idle gap allowed between comwake end and align start (53.3 ns)
`define WAKE_IDLE_MAX_PS 53300
`define WAKE_IDLE_MAX_CYC `PS_FLOOR_CYC(`WAKE_IDLE_MAX_PS)
// reset detector gap window around the nominal 320 ns spacing
`define RST_GAP_MIN_PS 240000
`define RST_GAP_MIN_CYC `PS_CEIL_CYC(`RST_GAP_MIN_PS)
`define RST_GAP_MAX_PS 400000
`define RST_GAP_MAX_CYC `PS_FLOOR_CYC(`RST_GAP_MAX_PS)
// bursts in one run needed before the reset detector fires; the first opens the run, the rest need good spacing
`define RST_BURSTS 3'h4

// register map (byte addresses on the wishbone bus)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define CTRL_RESET 8'h02
// control fields
`define CTRL_MAXSPD_LSB 0
`define CTRL_EXTEND_BIT 2
`define CTRL_COMINIT_BIT 3
// status fields
`define STAT_STATE_LSB 0
`define STAT_SPEED_LSB 4
`define STAT_PHYRDY_BIT 6
`define STAT_LINKUP_BIT 7
`define STAT_RESUME_BIT 8
`define STAT_RSTDET_BIT 9

`endif

/* File: logic/oob_init_pkg.sv */
// Purpose: types shared by the out-of-band bring-up block
// Assumes: nothing
// Notes: state codes follow a gray path from reset to ready
package oob_init_pkg;
	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_COMINIT = 4'h1,
		ST_AWAIT_WAKE = 4'h3,
		ST_AWAIT_NOWAKE = 4'h2,
		ST_COMWAKE = 4'h6,
		ST_SEND_ALIGN = 4'h7,
		ST_READY = 4'h5,
		ST_PARTIAL = 4'h4,
		ST_SLUMBER = 4'hc,
		ST_REDUCE = 4'hd,
		ST_ERROR = 4'hf
	} dev_state_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_COMINIT = 3'h1,
		TX_COMWAKE = 3'h2,
		TX_D10_2 = 3'h3,
		TX_ALIGN = 3'h4,
		TX_LINK = 3'h5
	} tx_kind_t;
endpackage

/* File: logic/oob_link_init.sv */
// Purpose: device side out-of-band bring-up, speed negotiation and power states
// Assumes: oob burst sender, comwake detector and primitive decoder sit outside
// Notes: registers reached over classic wishbone, one aligned word each
// What this block does
// - timeout at lowest speed enters the error state
// - no idle gap after comwake before align
// - device resume keeps speed, never reduces it
// - host align detected moves to ready
// - ignore early align noise; optional longer wait
// - reduce speed, wait valid signal, resend align
// - error holds unless resume failed, then comwake
// - ready sends link words, phyrdy when synced
// - link partial or slumber request leaves ready
// - partial exit: comwake or await host wake end
// - slumber exit: comwake or await host wake end
// - received host reset acts as hard reset
// - reset detector needs four bursts, bad spacing negates
// - reset release answered with cominit; cominit anytime
// - link up after three non-align primitives
// - reset forces reset state from any state
// - align starts fastest; d10.2 while pll unlocked
// - comwake done always moves to align sending
// - resume skips calibration straight to comwake
`timescale 1ns/1ps
`default_nettype none
`include "oob_init_defines.svh"

module oob_link_init #(
	parameter int unsigned ALIGN_WAIT_LONG_CYC = `ALIGN_WAIT_LONG_CYC // extended align window
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	// line side status from analog front end and decoders
	input wire logic i_rx_burst,
	input wire logic i_comwake_det,
	input wire logic i_oob_done,
	input wire logic i_rx_align,
	input wire logic i_rx_prim,
	input wire logic i_pll_locked,
	input wire logic i_speed_done,
	input wire logic i_rx_sync,
	input wire logic i_tx_valid,
	// link layer side
	input wire logic i_partial,
	input wire logic i_slumber,
	input wire logic [31:0] i_link_data,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// transmit and power control
	output oob_init_pkg::tx_kind_t o_tx_kind,
	output logic [31:0] o_tx_data,
	output logic [1:0] o_speed,
	output logic o_phyrdy,
	output logic o_link_up,
	output logic o_power_partial,
	output logic o_power_slumber,
	output logic o_error
);
	localparam logic [12:0] WAIT_LAST = 13'(`ALIGN_WAIT_CYC - 1);
	localparam logic [12:0] LONG_LAST = 13'(ALIGN_WAIT_LONG_CYC - 1);
	localparam logic [12:0] BLANK = 13'(`ALIGN_BLANK_CYC);

	oob_init_pkg::dev_state_t state; // current bring-up state
	oob_init_pkg::dev_state_t next_state; // state for the next edge
	oob_init_pkg::tx_kind_t next_tx_kind; // what the line carries next
	logic [12:0] timer; // cycles spent in the current align window
	logic resuming; // bring-up is a resume from a power state
	logic wake_seen; // host comwake was noticed while in partial
	logic [1:0] non_align; // consecutive non-align primitives in ready
	logic [7:0] ctrl; // software control byte
	logic cominit_kick; // one-cycle request to start cominit
	logic comreset; // host reset detector output

	// host reset burst train detector
	comreset_detect u_rst_det (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_rx_burst(i_rx_burst),
		.o_comreset(comreset)
	);

	// decode of control fields
	wire [1:0] max_speed = ctrl[`CTRL_MAXSPD_LSB +: 2];
	wire extend = ctrl[`CTRL_EXTEND_BIT];
	wire [12:0] align_last = extend ? LONG_LAST : WAIT_LAST;
	wire window_done = timer == align_last;
	// crosstalk right after comwake must not look like a host align
	wire align_ok = i_rx_align && (timer >= BLANK);
	wire in_align = state == oob_init_pkg::ST_SEND_ALIGN;
	wire enter_align = (next_state == oob_init_pkg::ST_SEND_ALIGN) && !in_align;
	wire leave_power = (state == oob_init_pkg::ST_PARTIAL || state == oob_init_pkg::ST_SLUMBER)
		&& next_state != state;

	// wishbone decode; ack answers one cycle after the strobe
	wire wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	wire hit_ctrl = i_wb_adr == `REG_CTRL;
	wire hit_stat = i_wb_adr == `REG_STATUS;
	wire ctrl_wr = wb_req && i_wb_we && hit_ctrl && i_wb_sel[0];
	wire [31:0] stat_word = {22'h0, comreset, resuming, o_link_up, o_phyrdy, o_speed, state};
	wire [31:0] rd_word = hit_ctrl ? {24'h0, ctrl} : (hit_stat ? stat_word : 32'h0);

	// next state; host reset overrides everything, software cominit next
	always_comb begin
		next_state = state;
		case (state)
			oob_init_pkg::ST_RESET: if (!comreset) next_state = oob_init_pkg::ST_COMINIT;
			oob_init_pkg::ST_COMINIT: if (i_oob_done) next_state = oob_init_pkg::ST_AWAIT_WAKE;
			oob_init_pkg::ST_AWAIT_WAKE: if (i_comwake_det) next_state = oob_init_pkg::ST_AWAIT_NOWAKE;
			// calibration is not built, so every path goes straight to comwake
			oob_init_pkg::ST_AWAIT_NOWAKE: if (!i_comwake_det) next_state = oob_init_pkg::ST_COMWAKE;
			oob_init_pkg::ST_COMWAKE: if (i_oob_done) next_state = oob_init_pkg::ST_SEND_ALIGN;
			oob_init_pkg::ST_SEND_ALIGN: begin
				if (align_ok)
					next_state = oob_init_pkg::ST_READY;
				else if (window_done && (resuming || o_speed == 2'h0))
					next_state = oob_init_pkg::ST_ERROR;
				else if (window_done)
					next_state = oob_init_pkg::ST_REDUCE;
			end
			oob_init_pkg::ST_REDUCE: if (i_speed_done) next_state = oob_init_pkg::ST_SEND_ALIGN;
			oob_init_pkg::ST_ERROR: if (resuming) next_state = oob_init_pkg::ST_COMWAKE;
			oob_init_pkg::ST_READY: begin
				if (i_partial)
					next_state = oob_init_pkg::ST_PARTIAL;
				else if (i_slumber)
					next_state = oob_init_pkg::ST_SLUMBER;
			end
			oob_init_pkg::ST_PARTIAL: begin
				if (!i_partial)
					next_state = (wake_seen || i_comwake_det) ?
						oob_init_pkg::ST_AWAIT_NOWAKE : oob_init_pkg::ST_COMWAKE;
			end
			oob_init_pkg::ST_SLUMBER: begin
				if (!i_slumber)
					next_state = i_comwake_det ?
						oob_init_pkg::ST_AWAIT_NOWAKE : oob_init_pkg::ST_COMWAKE;
			end
			default: next_state = oob_init_pkg::ST_RESET;
		endcase
		if (cominit_kick)
			next_state = oob_init_pkg::ST_COMINIT;
		if (comreset)
			next_state = oob_init_pkg::ST_RESET;
	end

	// line content follows the coming state so no idle cycle is inserted
	always_comb begin
		case (next_state)
			oob_init_pkg::ST_COMINIT: next_tx_kind = oob_init_pkg::TX_COMINIT;
			oob_init_pkg::ST_COMWAKE: next_tx_kind = oob_init_pkg::TX_COMWAKE;
			oob_init_pkg::ST_SEND_ALIGN, oob_init_pkg::ST_REDUCE:
				next_tx_kind = i_pll_locked ? oob_init_pkg::TX_ALIGN : oob_init_pkg::TX_D10_2;
			oob_init_pkg::ST_READY: next_tx_kind = oob_init_pkg::TX_LINK;
			default: next_tx_kind = oob_init_pkg::TX_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			state <= oob_init_pkg::ST_RESET;
		else
			state <= next_state;
	end

	// align window timer, restarted on entry and after each speed step
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			timer <= 13'h0;
		else if (enter_align)
			timer <= 13'h0;
		else if (in_align && !window_done)
			timer <= timer + 13'h1;
	end

	// speed: fastest on a fresh start, one step down per failed window
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			o_speed <= 2'h0;
		else if (state == oob_init_pkg::ST_COMWAKE && enter_align && !resuming)
			o_speed <= max_speed;
		else if (in_align && next_state == oob_init_pkg::ST_REDUCE)
			o_speed <= o_speed - 2'h1;
	end

	// resume bookkeeping; held through errors so a failed resume retries
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			resuming <= 1'b0;
			wake_seen <= 1'b0;
		end else begin
			if (next_state == oob_init_pkg::ST_RESET || next_state == oob_init_pkg::ST_COMINIT
				|| next_state == oob_init_pkg::ST_READY)
				resuming <= 1'b0;
			else if (leave_power)
				resuming <= 1'b1;
			if (state != oob_init_pkg::ST_PARTIAL)
				wake_seen <= 1'b0;
			else if (i_comwake_det)
				wake_seen <= 1'b1;
		end
	end

	// link-up after three non-align primitives in ready with no align primitive between them
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			non_align <= 2'h0;
		else if (state != oob_init_pkg::ST_READY || (i_rx_prim && i_rx_align))
			non_align <= 2'h0;
		else if (i_rx_prim && non_align != 2'h3)
			non_align <= non_align + 2'h1;
	end

	// registered outputs toward the line and the link layer
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_tx_kind <= oob_init_pkg::TX_IDLE;
			o_tx_data <= 32'h0;
			o_phyrdy <= 1'b0;
			o_link_up <= 1'b0;
			o_power_partial <= 1'b0;
			o_power_slumber <= 1'b0;
			o_error <= 1'b0;
		end else begin
			o_tx_kind <= next_tx_kind;
			o_tx_data <= (next_state == oob_init_pkg::ST_READY) ? i_link_data : 32'h0;
			o_phyrdy <= state == oob_init_pkg::ST_READY && i_rx_sync && i_tx_valid;
			o_link_up <= state == oob_init_pkg::ST_READY && non_align == 2'h3;
			o_power_partial <= next_state == oob_init_pkg::ST_PARTIAL;
			o_power_slumber <= next_state == oob_init_pkg::ST_SLUMBER;
			o_error <= next_state == oob_init_pkg::ST_ERROR;
		end
	end

	// wishbone slave: control byte, cominit kick, read mux
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl <= `CTRL_RESET;
			cominit_kick <= 1'b0;
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= wb_req;
			if (wb_req)
				o_wb_dat <= rd_word;
			if (ctrl_wr)
				ctrl <= {4'h0, 1'b0, i_wb_dat[2:0]};
			cominit_kick <= ctrl_wr && i_wb_dat[`CTRL_COMINIT_BIT];
		end
	end

	// checks
	AST_ALIGN_TIMEOUT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		in_align && window_done && !align_ok && o_speed == 2'h0 && !comreset && !cominit_kick
		|=> state == oob_init_pkg::ST_ERROR && o_error)
		else $error("align window at lowest speed did not end in error");
	AST_WAKE_NO_IDLE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		state == oob_init_pkg::ST_COMWAKE && i_oob_done && !comreset && !cominit_kick
		|=> (o_tx_kind == oob_init_pkg::TX_ALIGN || o_tx_kind == oob_init_pkg::TX_D10_2))
		else $error("line went idle after comwake");
	AST_RESUME_SPEED: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		resuming && in_align |=> state != oob_init_pkg::ST_REDUCE && $stable(o_speed))
		else $error("speed changed during resume");
	AST_READY_ON_ALIGN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		in_align && align_ok && !comreset && !cominit_kick
		|=> state == oob_init_pkg::ST_READY && o_tx_kind == oob_init_pkg::TX_LINK)
		else $error("host align did not bring ready");
	AST_BLANK: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		in_align && timer < BLANK |=> state != oob_init_pkg::ST_READY)
		else $error("align accepted inside the blanking time");
	AST_REDUCE_STEP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		in_align && next_state == oob_init_pkg::ST_REDUCE
		|=> o_speed == $past(o_speed) - 2'h1 && state == oob_init_pkg::ST_REDUCE)
		else $error("speed step wrong");
	AST_ERROR_HOLD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		state == oob_init_pkg::ST_ERROR && !resuming && !comreset && !cominit_kick
		|=> state == oob_init_pkg::ST_ERROR)
		else $error("error state left without cause");
	AST_PHYRDY: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_phyrdy |-> $past(state) == oob_init_pkg::ST_READY && $past(i_rx_sync) && $past(i_tx_valid))
		else $error("phyrdy without ready and sync");
	AST_PARTIAL_FIRST: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		state == oob_init_pkg::ST_READY && i_partial && !comreset && !cominit_kick
		|=> state == oob_init_pkg::ST_PARTIAL ##0 o_power_partial && !o_power_slumber)
		else $error("partial request not taken first");
	AST_HOST_RESET: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		comreset |=> state == oob_init_pkg::ST_RESET && o_tx_kind == oob_init_pkg::TX_IDLE)
		else $error("host reset did not force reset state");
endmodule // oob_link_init
`default_nettype wire

/* File: verif/host_oob_model.sv */
// Purpose: host side of the serial link as seen by the device bring-up block
// Assumes: decoder outputs of the device are driven here, idle level low
// Notes: tasks are called by the bench at a rising edge; all task drives are non-blocking
`timescale 1ns/1ps
`default_nettype none

module host_oob_model (
	input wire logic i_clock,
	output logic o_rx_burst,
	output logic o_comwake_det,
	output logic o_rx_align,
	output logic o_rx_prim
);
	// burst about 106.7 ns, gap about 320 ns, both in 25 ns core cycles
	localparam int BURST_CYC = 4;
	localparam int GAP_CYC = 13;

	// quiet line until the bench asks for something
	initial begin
		o_rx_burst = 1'b0;
		o_comwake_det = 1'b0;
		o_rx_align = 1'b0;
		o_rx_prim = 1'b0;
	end

	// only the host makes a reset train; sent after hard reset is released
	// the model has no receive path, so device traffic is ignored until the train is out
	task automatic comreset();
		repeat (6) begin
			o_rx_burst <= 1'b1;
			repeat (BURST_CYC) @(posedge i_clock);
			o_rx_burst <= 1'b0;
			repeat (GAP_CYC) @(posedge i_clock);
		end
		// line stays quiet past the longest gap so the release is seen
		repeat (24) @(posedge i_clock);
	endtask

	// wake detector level, held by the bench as long as it likes
	task automatic wake(input logic lvl);
		o_comwake_det <= lvl;
	endtask

	// one echoed align primitive
	task automatic align();
		o_rx_align <= 1'b1;
		o_rx_prim <= 1'b1;
		@(posedge i_clock);
		o_rx_align <= 1'b0;
		o_rx_prim <= 1'b0;
	endtask

	// back-to-back non-align primitives, the device side counts them
	task automatic prims(input int n);
		o_rx_prim <= 1'b1;
		repeat (n) @(posedge i_clock);
		o_rx_prim <= 1'b0;
	endtask
endmodule // host_oob_model

`default_nettype wire

/* File: verif/tb_oob_link_init.sv */
// Purpose: self-checking bench for the device out-of-band bring-up block
// Assumes: host partner model drives the line-side decoder inputs
// Notes: states read back through the status register over wishbone
`timescale 1ns/1ps
`default_nettype none

module tb_oob_link_init;
	logic clk, rst_n, oob_done, pll, spd_done, rx_sync, tx_valid, partial, slumber; // bench drives
	logic cyc, stb, we, ack, phyrdy, link_up, pp, ps, err;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] link_data, wdat, rdat, tx_data, q;
	logic [1:0] speed;
	wire logic burst, wake, ral, rprim; // host model outputs
	oob_init_pkg::tx_kind_t tx_kind;
	int fail_count, num_checks, n;

	oob_link_init uut (.i_clock(clk), .i_rst_n(rst_n), .i_rx_burst(burst), .i_comwake_det(wake),
		.i_oob_done(oob_done), .i_rx_align(ral), .i_rx_prim(rprim), .i_pll_locked(pll),
		.i_speed_done(spd_done), .i_rx_sync(rx_sync), .i_tx_valid(tx_valid), .i_partial(partial),
		.i_slumber(slumber), .i_link_data(link_data), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .o_tx_kind(tx_kind), .o_tx_data(tx_data), .o_speed(speed),
		.o_phyrdy(phyrdy), .o_link_up(link_up), .o_power_partial(pp), .o_power_slumber(ps),
		.o_error(err));
	host_oob_model host (.i_clock(clk), .o_rx_burst(burst), .o_comwake_det(wake),
		.o_rx_align(ral), .o_rx_prim(rprim));

	// free running 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// compare and count; four-state compare so unknowns never match
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one classic wishbone cycle; waits for ack with a bound, not a fixed latency
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		q = rdat;
		if (k >= 50) fail_count++;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask

	// burst sender reports its train finished
	task automatic done_pulse();
		oob_done <= 1'b1;
		@(posedge clk);
		oob_done <= 1'b0;
		@(posedge clk);
	endtask

	// from cominit through host wake to the align sending state
	task automatic to_align();
		done_pulse();
		host.wake(1'b1);
		tick(4);
		host.wake(1'b0);
		tick(2);
		check({29'h0, tx_kind}, 32'h2);
		done_pulse();
	endtask

	// bounded wait until the error output rises, cycles counted in n
	task automatic wait_err();
		n = 0;
		while (err !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic report_and_stop();
		if (fail_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// watchdog sized well beyond the four align windows the tests use
	initial begin
		tick(40000);
		fail_count++;
		report_and_stop();
	end

	initial begin
		{rst_n, oob_done, pll, spd_done, partial, slumber, cyc, stb, we} = '0;
		{rx_sync, tx_valid} = 2'b11;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
		link_data = 32'h5a5ac3c3;
		fail_count = 0;
		num_checks = 0;
		tick(11);
		check({29'h0, tx_kind}, 32'h0);
		@(posedge clk);
		rst_n <= 1'b1;
		tick(2);
		check({29'h0, tx_kind}, 32'h1);
		// register map: reset value, read only status, unmapped place
		wb(1'b0, 8'h00, 32'h0);
		check(q, 32'h2);
		wb(1'b1, 8'h04, 32'hffffffff);
		wb(1'b0, 8'h04, 32'h0);
		check({28'h0, q[3:0]}, 32'h1);
		wb(1'b1, 8'h08, 32'hffffffff);
		wb(1'b0, 8'h08, 32'h0);
		check(q, 32'h0);
		// fresh start: fastest speed, d10.2 while the pll is unlocked
		to_align();
		check({29'h0, tx_kind}, 32'h3);
		check({30'h0, speed}, 32'h2);
		pll <= 1'b1;
		tick(2);
		check({29'h0, tx_kind}, 32'h4);
		// align in the blanking window after wake is not trusted
		host.align();
		tick(2);
		check({29'h0, tx_kind}, 32'h4);
		tick(25);
		host.align();
		tick(2);
		check({29'h0, tx_kind}, 32'h5);
		check(tx_data, 32'h5a5ac3c3);
		tick(1);
		check({31'h0, phyrdy}, 32'h1);
		rx_sync <= 1'b0;
		tick(3);
		check({31'h0, phyrdy}, 32'h0);
		rx_sync <= 1'b1;
		host.prims(3);
		tick(3);
		check({31'h0, link_up}, 32'h1);
		// both power requests: partial wins and holds while asserted
		partial <= 1'b1;
		slumber <= 1'b1;
		tick(2);
		check({30'h0, pp, ps}, 32'h2);
		slumber <= 1'b0;
		tick(3);
		check({31'h0, pp}, 32'h1);
		partial <= 1'b0;
		tick(2);
		check({29'h0, tx_kind}, 32'h2);
		// failed device resume: no speed drop, error then comwake again
		done_pulse();
		wait_err();
		check({30'h0, speed}, 32'h2);
		check({31'h0, n >= 2170 && n <= 2190}, 32'h1);
		tick(3);
		check({29'h0, tx_kind}, 32'h2);
		done_pulse();
		tick(28);
		host.align();
		tick(2);
		check({29'h0, tx_kind}, 32'h5);
		// slumber exit while the host wake is still on the line
		slumber <= 1'b1;
		tick(2);
		check({30'h0, pp, ps}, 32'h1);
		host.wake(1'b1);
		slumber <= 1'b0;
		tick(2);
		wb(1'b0, 8'h04, 32'h0);
		check({28'h0, q[3:0]}, 32'h2);
		host.wake(1'b0);
		tick(2);
		check({29'h0, tx_kind}, 32'h2);
		// host reset mid-run: reset state while bursts arrive, cominit on release
		fork
			host.comreset();
			begin
				tick(80);
				check({29'h0, tx_kind}, 32'h0);
			end
		join
		check({29'h0, tx_kind}, 32'h1);
		check({30'h0, link_up, phyrdy}, 32'h0);
		// speed steps down from max 1, then error holds at the lowest
		wb(1'b1, 8'h00, 32'h1);
		to_align();
		check({30'h0, speed}, 32'h1);
		n = 0;
		while (speed !== 2'h0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, n >= 2170 && n <= 2190}, 32'h1);
		tick(20);
		wb(1'b0, 8'h04, 32'h0);
		check({28'h0, q[3:0]}, 32'hd);
		spd_done <= 1'b1;
		tick(2);
		check({29'h0, tx_kind}, 32'h4);
		spd_done <= 1'b0;
		wait_err();
		check({31'h0, n >= 2165 && n <= 2190}, 32'h1);
		tick(50);
		check({31'h0, err}, 32'h1);
		// software cominit kick works from the error state and reads back zero
		wb(1'b1, 8'h00, 32'h9);
		tick(1);
		check({29'h0, tx_kind}, 32'h1);
		wb(1'b0, 8'h00, 32'h0);
		check(q, 32'h1);
		// extended window at the lowest speed: twice as long, then error
		wb(1'b1, 8'h00, 32'h4);
		to_align();
		check({30'h0, speed}, 32'h0);
		wait_err();
		check({31'h0, n >= 4360 && n <= 4380}, 32'h1);
		report_and_stop();
	end
endmodule // tb_oob_link_init

`default_nettype wire
